// File: rtl/dmacp_cfg.svh
`ifndef DMACP_CFG_SVH
`define DMACP_CFG_SVH
// Overview of operation
// RQ1: Each async context keeps a pointer to its first block, used on run.
// RQ2: Async pointers decode at 18Ch, 1ACh, 1CCh and 1ECh.
// RQ3: Pointer bits 31:4 are the upper 28 bits of a 16-byte block address.
// RQ4: Pointer bits 3:0 count descriptors; zero marks the address invalid.
// RQ5: Eight iso transmit contexts; set port 200h+16n, clear port 204h+16n.
// RQ6: With match enable (bit 31) set, first packet goes in the matched cycle.
// RQ7: Match field, bits 30:16, is two seconds bits and 13 cycle bits.
// RQ8: Context enables when timer seconds low bits and cycle count match.
// RQ9: Match is checked on the cycle start just before transmission.
// RQ10: Hardware clears match enable once the context becomes active. Here a software set in that same cycle survives.
// RQ11: Engine may fetch the first block before its transmit cycle.
// RQ12: Software sets run to start, clears to stop; hardware only on reset.
// RQ13: Software sets wake to resume; hardware clears it on every fetch. Here a software set in the fetch cycle wins over the clear.
// RQ14: Control bits 14:13 are reserved and read as zero.
// RQ15: Dead flag set on fatal error, cleared when software clears run.
// RQ16: Active flag is one while descriptors are being processed.
// RQ17: Ones to set port set bits, to clear port clear; both read back.

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DMACP_OFS_ARQ_TX 12'h18c
`define DMACP_OFS_ARS_TX 12'h1ac
`define DMACP_OFS_ARQ_RX 12'h1cc
`define DMACP_OFS_ARS_RX 12'h1ec
`define DMACP_OFS_ITX_SET 12'h200
`define DMACP_OFS_ITX_CLR 12'h204
`define DMACP_ITX_STRIDE 12'h010
`define DMACP_ITX_COUNT 8
`define DMACP_ASYNC_COUNT 4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DMACP_PTR_ADDR_MSB 31
`define DMACP_PTR_ADDR_LSB 4
`define DMACP_PTR_Z_MSB 3
`define DMACP_PTR_Z_LSB 0
`define DMACP_CTL_MATCH_EN 31
`define DMACP_CTL_MATCH_MSB 30
`define DMACP_CTL_MATCH_LSB 16
`define DMACP_CTL_RUN 15
`define DMACP_CTL_WAKE 12
`define DMACP_CTL_DEAD 11
`define DMACP_CTL_ACTIVE 10
`define DMACP_CTL_EVT_MSB 4
`define DMACP_CTL_EVT_LSB 0
`define DMACP_TMR_SEC_LSB 25
`define DMACP_TMR_SEC_LOW_MSB 26
`define DMACP_TMR_CYC_MSB 24
`define DMACP_TMR_CYC_LSB 12

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define DMACP_PTR_RESET 32'h0000_0000
`define DMACP_CTL_SW_MASK 32'hffff_9000
`endif

// File: rtl/dmacp_pkg.sv
package dmacp_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRDATA,
    ST_RDWAIT
  } dmacp_phase_e;

  typedef logic [14:0] dmacp_stamp_t;
  typedef logic [4:0] dmacp_evt_t;
endpackage : dmacp_pkg

// File: rtl/dmacp_itx_ctx.sv
`timescale 1ns/1ns
`include "dmacp_cfg.svh"
module dmacp_itx_ctx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic soft_reset,
  input wire logic set_we,
  input wire logic clr_we,
  input wire logic [31:0] wdata,
  input wire logic cycle_start,
  input wire dmacp_pkg::dmacp_stamp_t cycle_stamp,
  input wire logic fetch,
  input wire logic fatal,
  input wire logic done,
  input wire logic event_we,
  input wire dmacp_pkg::dmacp_evt_t event_code,
  output logic [31:0] ctrl,
  output logic run_r,
  output logic wake_r,
  output logic active_r,
  output logic prefetch_r
);
  logic match_en_r;
  logic match_en_nxt;
  dmacp_pkg::dmacp_stamp_t match_r;
  dmacp_pkg::dmacp_stamp_t match_nxt;
  logic run_nxt;
  logic wake_nxt;
  logic dead_r;
  logic dead_nxt;
  logic active_nxt;
  dmacp_pkg::dmacp_evt_t evt_r;
  dmacp_pkg::dmacp_evt_t evt_nxt;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic hit;
  logic go;

  assign set_bits = set_we ? (wdata & `DMACP_CTL_SW_MASK) : 32'h0000_0000;
  assign clr_bits = clr_we ? (wdata & `DMACP_CTL_SW_MASK) : 32'h0000_0000;

  // Compared only on a cycle start strobe [RQ9]
  assign hit = cycle_start && (cycle_stamp == match_r); // [RQ8]
  // Start immediately, or wait for the matched cycle [RQ6]
  assign go = run_r && !dead_r && !active_r && (!match_en_r || hit);

  // Set-and-clear in one port pair; run changes by software or soft reset only [RQ17]
  assign run_nxt = soft_reset ? 1'b0 :
    ((run_r | set_bits[`DMACP_CTL_RUN]) & ~clr_bits[`DMACP_CTL_RUN]); // [RQ12]
  assign match_nxt = soft_reset ? 15'h0000 :
    ((match_r | set_bits[`DMACP_CTL_MATCH_MSB:`DMACP_CTL_MATCH_LSB]) &
     ~clr_bits[`DMACP_CTL_MATCH_MSB:`DMACP_CTL_MATCH_LSB]); // [RQ7]
  // A software set in the start cycle survives the hardware clear
  assign match_en_nxt = soft_reset ? 1'b0 :
    (set_bits[`DMACP_CTL_MATCH_EN] |
     (match_en_r & ~go & ~clr_bits[`DMACP_CTL_MATCH_EN])); // [RQ10]
  // Software set beats fetch clear so a resume is never lost
  assign wake_nxt = soft_reset ? 1'b0 :
    (set_bits[`DMACP_CTL_WAKE] |
     (wake_r & ~fetch & ~clr_bits[`DMACP_CTL_WAKE])); // [RQ13]
  assign dead_nxt = soft_reset ? 1'b0 :
    ((fatal & run_r) | (dead_r & run_nxt)); // [RQ15]
  assign active_nxt = soft_reset ? 1'b0 :
    (go | (active_r & run_nxt & ~fatal & ~done)); // [RQ16]
  assign evt_nxt = soft_reset ? 5'h00 : (event_we ? event_code : evt_r);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      match_en_r <= 1'b0;
      match_r <= 15'h0000;
      run_r <= 1'b0;
      wake_r <= 1'b0;
      dead_r <= 1'b0;
      active_r <= 1'b0;
      evt_r <= 5'h00;
      prefetch_r <= 1'b0;
    end
    else
    begin
      match_en_r <= match_en_nxt;
      match_r <= match_nxt;
      run_r <= run_nxt;
      wake_r <= wake_nxt;
      dead_r <= dead_nxt;
      active_r <= active_nxt;
      evt_r <= evt_nxt;
      // Fetch may start before the matched cycle [RQ11]
      prefetch_r <= run_nxt & ~dead_nxt;
    end
  end

  // Reserved 14:13 and 9:5 tie to zero [RQ14]
  assign ctrl = {match_en_r, match_r, run_r, 2'b00, wake_r, dead_r,
                 active_r, 5'b00000, evt_r};
endmodule : dmacp_itx_ctx

// File: rtl/dmacp_top.sv
`timescale 1ns/1ns
`include "dmacp_cfg.svh"
module dmacp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic soft_reset,
  input wire logic [3:0] async_run,
  output logic [3:0] async_start,
  output logic [31:0] async_req_tx_ptr,
  output logic [31:0] async_resp_tx_ptr,
  output logic [31:0] async_req_rx_ptr,
  output logic [31:0] async_resp_rx_ptr,
  input wire logic [31:0] cycle_timer,
  input wire logic cycle_start,
  input wire logic [7:0] itx_fetch,
  input wire logic [7:0] itx_fatal,
  input wire logic [7:0] itx_done,
  input wire logic [7:0] itx_event_we,
  input wire logic [4:0] itx_event_code,
  output logic [7:0] itx_run,
  output logic [7:0] itx_wake,
  output logic [7:0] itx_active,
  output logic [7:0] itx_prefetch
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Index of an async pointer word, or 4 when none matches
  function automatic logic [2:0] async_index(input logic [11:0] a);
    logic [2:0] idx;
    idx = 3'd4;
    case (a)
      `DMACP_OFS_ARQ_TX: idx = 3'd0;
      `DMACP_OFS_ARS_TX: idx = 3'd1;
      `DMACP_OFS_ARQ_RX: idx = 3'd2;
      `DMACP_OFS_ARS_RX: idx = 3'd3;
      default: idx = 3'd4;
    endcase
    return idx;
  endfunction : async_index

  // True when the word falls in the iso transmit control window
  function automatic logic itx_hit(input logic [11:0] a);
    logic in_range;
    in_range = (a >= `DMACP_OFS_ITX_SET) &&
      (a < (`DMACP_OFS_ITX_SET + `DMACP_ITX_STRIDE * 12'd8));
    return in_range && (a[3:0] == 4'h0 || a[3:0] == 4'h4);
  endfunction : itx_hit

  // Two low seconds bits joined with the cycle count
  function automatic dmacp_pkg::dmacp_stamp_t stamp_of(
    input logic [31:0] t);
    return {t[`DMACP_TMR_SEC_LOW_MSB:`DMACP_TMR_SEC_LSB],
            t[`DMACP_TMR_CYC_MSB:`DMACP_TMR_CYC_LSB]}; // [RQ7] [RQ8]
  endfunction : stamp_of

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  dmacp_pkg::dmacp_phase_e phase_r;
  dmacp_pkg::dmacp_phase_e phase_nxt;
  logic [11:0] waddr_r;
  logic [11:0] raddr_r;
  logic [11:0] raddr_nxt;
  logic [31:0] rdata_nxt;
  logic ready_nxt;
  logic take;
  logic take_wr;
  logic take_rd;
  logic [11:0] req_addr;

  assign req_addr = haddr[11:0];
  assign take = hsel && htrans[1] && hready;
  assign take_wr = take && hwrite;
  assign take_rd = take && !hwrite;

  // ----------------------------------------------------------------
  // Write decode (data phase)
  // ----------------------------------------------------------------
  logic wr_now;
  logic [2:0] wr_async;
  logic wr_itx;
  logic [2:0] wr_ctx;
  logic wr_is_clr;
  logic [3:0] ptr_we;
  logic [7:0] set_we;
  logic [7:0] clr_we;

  assign wr_now = (phase_r == dmacp_pkg::ST_WRDATA);
  assign wr_async = async_index(waddr_r);
  assign wr_itx = itx_hit(waddr_r);
  assign wr_ctx = waddr_r[6:4]; // [RQ5]
  assign wr_is_clr = waddr_r[2];

  genvar gi;
  generate
    for (gi = 0; gi < `DMACP_ASYNC_COUNT; gi = gi + 1)
    begin : g_ptr_we
      assign ptr_we[gi] = wr_now && (wr_async == 3'(gi)); // [RQ2]
    end
    for (gi = 0; gi < `DMACP_ITX_COUNT; gi = gi + 1)
    begin : g_itx_we
      assign set_we[gi] = wr_now && wr_itx && !wr_is_clr &&
        (wr_ctx == 3'(gi)); // [RQ17]
      assign clr_we[gi] = wr_now && wr_itx && wr_is_clr &&
        (wr_ctx == 3'(gi)); // [RQ17]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Async command pointers
  // ----------------------------------------------------------------
  // Not cleared by soft reset: software rewrites it before each run
  logic [31:0] ptr_r [4];
  logic [3:0] run_q_r;
  logic [3:0] start_nxt;
  logic [3:0] ptr_ok;

  generate
    for (gi = 0; gi < `DMACP_ASYNC_COUNT; gi = gi + 1)
    begin : g_ptr
      // Zero count means no usable address [RQ4]
      assign ptr_ok[gi] =
        (ptr_r[gi][`DMACP_PTR_Z_MSB:`DMACP_PTR_Z_LSB] != 4'h0);
      // Fetch begins on the run rising edge [RQ1]
      assign start_nxt[gi] = async_run[gi] && !run_q_r[gi] && ptr_ok[gi];
    end
  endgenerate

  // One process owns every pointer word
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int k = 0; k < `DMACP_ASYNC_COUNT; k++)
        ptr_r[k] <= `DMACP_PTR_RESET;
    end
    else
    begin
      for (int k = 0; k < `DMACP_ASYNC_COUNT; k++)
        if (ptr_we[k])
          ptr_r[k] <= hwdata; // [RQ3]
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q_r <= 4'h0;
      async_start <= 4'h0;
    end
    else
    begin
      run_q_r <= async_run;
      async_start <= start_nxt; // [RQ1]
    end
  end

  // Block addresses reach the engine with the low nibble forced to zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      async_req_tx_ptr <= `DMACP_PTR_RESET;
      async_resp_tx_ptr <= `DMACP_PTR_RESET;
      async_req_rx_ptr <= `DMACP_PTR_RESET;
      async_resp_rx_ptr <= `DMACP_PTR_RESET;
    end
    else
    begin
      async_req_tx_ptr <= {ptr_r[0][31:4], 4'h0}; // [RQ3]
      async_resp_tx_ptr <= {ptr_r[1][31:4], 4'h0}; // [RQ3]
      async_req_rx_ptr <= {ptr_r[2][31:4], 4'h0}; // [RQ3]
      async_resp_rx_ptr <= {ptr_r[3][31:4], 4'h0}; // [RQ3]
    end
  end

  // ----------------------------------------------------------------
  // Iso transmit contexts
  // ----------------------------------------------------------------
  logic [31:0] ctrl_w [8];
  dmacp_pkg::dmacp_stamp_t stamp;

  assign stamp = stamp_of(cycle_timer);

  generate
    for (gi = 0; gi < `DMACP_ITX_COUNT; gi = gi + 1)
    begin : g_itx
      dmacp_itx_ctx u_ctx (
        .hclk(hclk),
        .hresetn(hresetn),
        .soft_reset(soft_reset),
        .set_we(set_we[gi]),
        .clr_we(clr_we[gi]),
        .wdata(hwdata),
        .cycle_start(cycle_start),
        .cycle_stamp(stamp),
        .fetch(itx_fetch[gi]),
        .fatal(itx_fatal[gi]),
        .done(itx_done[gi]),
        .event_we(itx_event_we[gi]),
        .event_code(itx_event_code),
        .ctrl(ctrl_w[gi]),
        .run_r(itx_run[gi]),
        .wake_r(itx_wake[gi]),
        .active_r(itx_active[gi]),
        .prefetch_r(itx_prefetch[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  logic [2:0] rd_async;
  logic rd_itx;
  logic [31:0] rd_async_val;
  logic [31:0] rd_val;
  logic [11:0] rd_addr;

  // Held address while stalled; keeps the read path free of a loop
  assign rd_addr = (phase_r == dmacp_pkg::ST_RDWAIT) ? raddr_r : req_addr;
  assign rd_async = async_index(rd_addr);
  assign rd_itx = itx_hit(rd_addr);
  assign rd_async_val = (rd_async[2]) ? 32'h0000_0000 :
    ptr_r[rd_async[1:0]];
  // Set and clear ports both return the live control word [RQ17]
  assign rd_val = rd_itx ? ctrl_w[rd_addr[6:4]] :
    rd_async_val;

  // ----------------------------------------------------------------
  // Bus sequencing
  // ----------------------------------------------------------------
  // A read right behind a write waits one cycle so it sees the update
  always_comb
  begin
    phase_nxt = dmacp_pkg::ST_IDLE;
    raddr_nxt = raddr_r;
    ready_nxt = 1'b1;
    rdata_nxt = hrdata;
    case (phase_r)
      dmacp_pkg::ST_IDLE:
      begin
        if (take_wr)
          phase_nxt = dmacp_pkg::ST_WRDATA;
        else if (take_rd)
        begin
          raddr_nxt = req_addr;
          rdata_nxt = rd_val;
        end
      end
      dmacp_pkg::ST_WRDATA:
      begin
        if (take_wr)
          phase_nxt = dmacp_pkg::ST_WRDATA;
        else if (take_rd)
        begin
          raddr_nxt = req_addr;
          phase_nxt = dmacp_pkg::ST_RDWAIT;
          ready_nxt = 1'b0;
        end
      end
      dmacp_pkg::ST_RDWAIT:
      begin
        rdata_nxt = rd_val;
      end
      default:
      begin
        phase_nxt = dmacp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_r <= dmacp_pkg::ST_IDLE;
      waddr_r <= 12'h000;
      raddr_r <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      if (take_wr)
        waddr_r <= req_addr;
      raddr_r <= raddr_nxt;
      hrdata <= rdata_nxt;
      hreadyout <= ready_nxt;
      // Unmapped words read zero and drop writes, still OKAY
      hresp <= 1'b0;
    end
  end

endmodule : dmacp_top

// File: tb/dmacp_props.sv
`timescale 1ns/1ns
module dmacp_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic soft_reset,
  input wire logic [3:0] async_run,
  input wire logic [3:0] async_start,
  input wire logic [31:0] async_req_tx_ptr,
  input wire logic [7:0] itx_fetch,
  input wire logic [7:0] itx_fatal,
  input wire logic [7:0] itx_done,
  input wire logic [7:0] itx_run,
  input wire logic [7:0] itx_wake,
  input wire logic [7:0] itx_active,
  input wire logic [7:0] itx_prefetch
);
  // ----
  // Data phase tracking
  // ----
  logic wdp_r;
  logic rdp_r;
  logic itx_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wdp_r <= 1'b0;
      rdp_r <= 1'b0;
      itx_r <= 1'b0;
    end
    else if (hready)
    begin
      wdp_r <= hsel & htrans[1] & hwrite;
      rdp_r <= hsel & htrans[1] & !hwrite;
      itx_r <= haddr[11:7] == 5'h04;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_itx_wr;
    wdp_r && itx_r;
  endsequence
  sequence s_fatal_run;
    itx_fatal[0] && itx_run[0];
  endsequence
  chk_run_cause: assert property
    ($changed(itx_run[0]) |-> $past(wdp_r && itx_r) || $past(soft_reset))
  else $error("run moved without write or reset");
  chk_fetch_wake: assert property
    (itx_fetch[0] && !wdp_r |=> !itx_wake[0])
  else $error("fetch left wake set");
  chk_start_rise: assert property
    (async_start[0] |-> $past(async_run[0]) && !$past(async_run[0], 2))
  else $error("start without run edge");
  chk_start_pulse: assert property
    (async_start[0] |=> !async_start[0])
  else $error("start longer than one cycle");
  chk_ptr_nibble: assert property (async_req_tx_ptr[3:0] == 4'h0)
  else $error("pointer low nibble not zero");
  chk_active_cause: assert property
    ($rose(itx_active[0]) |-> $past(itx_prefetch[0]))
  else $error("active without run");
  chk_done_idle: assert property
    (itx_done[0] && itx_active[0] |=> !itx_active[0])
  else $error("done left active");
  chk_fatal_dead: assert property
    (s_fatal_run |=> !itx_prefetch[0] && !itx_active[0])
  else $error("fatal did not stop context");
  chk_resv_zero: assert property
    (hready && rdp_r && itx_r |->
      hrdata[14:13] == 2'h0 && hrdata[9:5] == 5'h0)
  else $error("reserved bits not zero");
  chk_stall_one: assert property (!hreadyout |=> hreadyout)
  else $error("stall longer than one cycle");
  chk_resp_okay: assert property (hresp == 1'b0)
  else $error("response not okay");
  cov_itx_wr: cover property (s_itx_wr);
endmodule : dmacp_props

bind dmacp_top dmacp_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .soft_reset(soft_reset), .async_run(async_run),
  .async_start(async_start), .async_req_tx_ptr(async_req_tx_ptr),
  .itx_fetch(itx_fetch), .itx_fatal(itx_fatal), .itx_done(itx_done),
  .itx_run(itx_run), .itx_wake(itx_wake), .itx_active(itx_active),
  .itx_prefetch(itx_prefetch));

// File: tb/dmacp_top_tb_top.sv
`timescale 1ns/1ns
module dmacp_top_tb_top;
  typedef struct {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } dmacp_tc_s;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic soft_reset, cycle_start;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] async_run, async_start;
  logic [4:0] itx_event_code;
  logic [7:0] itx_fetch, itx_fatal, itx_done, itx_event_we;
  logic [7:0] itx_run, itx_wake, itx_active, itx_prefetch;
  logic [31:0] haddr, hwdata, hrdata, cycle_timer, rd;
  logic [31:0] p0, p1, p2, p3;
  int err_count, checked, i;
  dmacp_tc_s rows[$];

  always #10 hclk = ~hclk;
  assign hready = hreadyout;

  dmacp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .soft_reset(soft_reset),
    .async_run(async_run), .async_start(async_start),
    .async_req_tx_ptr(p0), .async_resp_tx_ptr(p1),
    .async_req_rx_ptr(p2), .async_resp_rx_ptr(p3),
    .cycle_timer(cycle_timer), .cycle_start(cycle_start),
    .itx_fetch(itx_fetch), .itx_fatal(itx_fatal), .itx_done(itx_done),
    .itx_event_we(itx_event_we), .itx_event_code(itx_event_code),
    .itx_run(itx_run), .itx_wake(itx_wake), .itx_active(itx_active),
    .itx_prefetch(itx_prefetch));

  // ----
  // Tasks
  // ----
  task report_and_stop;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step

  // Bounded wait for hready at a rising edge
  task wt;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      report_and_stop();
    end
  endtask : wt

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask : bus

  task cyc(input logic [31:0] t);
    cycle_timer <= t;
    cycle_start <= 1'b1;
    step(1);
    cycle_start <= 1'b0;
    step(1);
  endtask : cyc

  // ----
  // Sequence
  // ----
  initial
  begin
    {hsel, hwrite, soft_reset, cycle_start} = 4'h0;
    {htrans, async_run, itx_event_code} = 11'h000;
    {itx_fetch, itx_fatal, itx_done, itx_event_we} = 32'h0;
    {haddr, hwdata, cycle_timer} = 96'h0;
    hsize = 3'h2;
    hresetn = 1'b0;
    step(6);
    hresetn <= 1'b1;
    step(1);
    chk("run_rst", 32'h0, {24'h0, itx_run});
    bus(1'b0, 32'h18c, 32'h0);
    chk("ptr_rst", 32'h0, rd);
    rows.push_back('{32'h18c, 32'h1234_5673, 32'h1234_5673});
    rows.push_back('{32'h1ac, 32'hcafe_bab1, 32'hcafe_bab1});
    rows.push_back('{32'h1cc, 32'h0f0f_0f0f, 32'h0f0f_0f0f});
    rows.push_back('{32'h1ec, 32'hffff_fffe, 32'hffff_fffe});
    rows.push_back('{32'h100, 32'hffff_ffff, 32'h0});
    for (i = 0; i < 8; i++)
    begin
      rows.push_back('{32'h200 + 16 * i, 32'h7fff_7000,
        32'h7fff_1000});
      rows.push_back('{32'h204 + 16 * i, 32'hffff_ffff, 32'h0});
    end
    foreach (rows[k])
    begin
      bus(1'b1, rows[k].a, rows[k].d);
      bus(1'b0, rows[k].a, 32'h0);
      chk("row", rows[k].e, rd);
    end
    chk("ptr0", 32'h1234_5670, p0);
    chk("ptr3", 32'hffff_fff0, p3);
    chk("ptr1", 32'hcafe_bab0, p1);
    chk("ptr2", 32'h0f0f_0f00, p2);
    async_run <= 4'h1;
    step(2);
    chk("start", 32'h1, {28'h0, async_start});
    step(1);
    chk("start_end", 32'h0, {28'h0, async_start});
    bus(1'b1, 32'h1ac, 32'h1000_0000);
    async_run <= 4'h3;
    step(2);
    chk("start_z", 32'h0, {28'h0, async_start});
    bus(1'b1, 32'h200, 32'h0000_8000);
    step(1);
    chk("run", 32'h1, {24'h0, itx_run});
    chk("pref", 32'h1, {24'h0, itx_prefetch});
    step(1);
    chk("active", 32'h1, {24'h0, itx_active});
    itx_event_code <= 5'h11;
    itx_event_we <= 8'h01;
    step(1);
    itx_event_we <= 8'h00;
    bus(1'b0, 32'h204, 32'h0);
    chk("ctl0", 32'h0000_8411, rd);
    bus(1'b1, 32'h200, 32'h0000_1000);
    step(1);
    chk("wake", 32'h1, {24'h0, itx_wake});
    itx_fetch <= 8'h01;
    step(1);
    itx_fetch <= 8'h00;
    step(1);
    chk("wake_clr", 32'h0, {24'h0, itx_wake});
    itx_done <= 8'h01;
    step(1);
    itx_done <= 8'h00;
    step(2);
    itx_fatal <= 8'h01;
    step(1);
    itx_fatal <= 8'h00;
    step(1);
    chk("pref_dead", 32'h0, {24'h0, itx_prefetch});
    bus(1'b0, 32'h200, 32'h0);
    chk("ctl_dead", 32'h0000_8811, rd);
    bus(1'b1, 32'h204, 32'h0000_8000);
    bus(1'b0, 32'h200, 32'h0);
    chk("ctl_stop", 32'h0000_0011, rd);
    // Matching stamp but no cycle start yet
    cycle_timer <= 32'hfaab_c000;
    bus(1'b1, 32'h210, 32'haabc_8000);
    step(3);
    chk("no_start", 32'h0, {24'h0, itx_active});
    cyc(32'hfaab_d000);
    chk("miss", 32'h0, {24'h0, itx_active});
    cyc(32'hfaab_c000);
    chk("hit", 32'h2, {24'h0, itx_active});
    bus(1'b0, 32'h214, 32'h0);
    chk("ctl1", 32'h2abc_8400, rd);
    soft_reset <= 1'b1;
    step(1);
    soft_reset <= 1'b0;
    step(1);
    chk("run_srst", 32'h0, {24'h0, itx_run});
    bus(1'b0, 32'h18c, 32'h0);
    chk("ptr_keep", 32'h1234_5673, rd);
    // Read pipelined behind a write stalls once and sees the new word
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'h1cc;
    hwrite <= 1'b1;
    wt();
    hwrite <= 1'b0;
    hwdata <= 32'h5555_aaa1;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    @(posedge hclk);
    chk("stall", 32'h0, {31'h0, hreadyout});
    wt();
    rd = hrdata;
    chk("rd_after_wr", 32'h5555_aaa1, rd);
    report_and_stop();
  end
endmodule : dmacp_top_tb_top
